// >>> rtl/csr_status.sv
// Common status reporting: status byte, event status, both enables, command engine.
// Assumes a parser feeds decoded common commands, synchronous to clk_sys.
`include "csr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module csr_status (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 por,
    // Decoded command from parser
    input  wire logic                 cmd_valid,
    input  wire csr_pkg::csr_cmd_t    cmd_code,
    input  wire logic [7:0]           cmd_arg,
    input  wire logic                 cmd_after_term,
    output logic                      cmd_ready,
    // Instrument side
    input  wire logic                 ops_pending,
    input  wire logic                 queue_busy,
    input  wire logic [7:0]           event_in,
    input  wire logic                 oper_summary,
    input  wire logic                 ques_summary,
    output logic                      err_q_clear,
    output logic [15:0]               pos_pol,
    output logic [15:0]               pos_quarter,
    output logic [15:0]               pos_half,
    output logic                      scan_fast,
    output logic                      test_start,
    input  wire logic                 test_done,
    input  wire logic [15:0]          test_result,
    // Output queue to bus
    output logic [7:0]                oq_data,
    output logic                      oq_valid,
    input  wire logic                 oq_read,
    // Bus service request and serial poll
    output logic                      srq,
    input  wire logic                 spoll_read,
    output logic [7:0]                spoll_byte
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  event_status_enable_r;
    logic [7:0]  event_status_r;
    logic [7:0]  service_request_enable_r;
    logic [7:0]  stb_cond;
    logic [7:0]  stb_prev_r;
    logic        rqs_r;
    logic [7:0]  oq_mem [`CSR_OQ_DEPTH];
    logic [2:0]  oq_wp_r;
    logic [2:0]  oq_rp_r;
    logic [3:0]  oq_cnt_r;
    logic        oq_push;
    logic [7:0]  oq_push_data;
    logic        oq_flush;
    logic        oq_do_push;
    logic        oq_do_pop;
    logic [15:0] sav_pol  [10];
    logic [15:0] sav_qtr  [10];
    logic [15:0] sav_half [10];
    logic        sav_fast [10];
    logic [15:0] tst_pol_r;
    logic [15:0] tst_qtr_r;
    logic [15:0] tst_half_r;
    logic        tst_fast_r;
    logic [7:0]  delay_r;
    logic [2:0]  emit_r;
    logic        opc_kind_r;
    csr_pkg::csr_state_t state_r;
    logic        take;
    logic        is_cls;

    assign take   = cmd_valid && cmd_ready;
    assign is_cls = take && cmd_code == csr_pkg::CSR_CMD_CLS;

    ////////////////////////////////////////////////////////////////////////
    // Status byte conditions; unused bits 2..0 stay zero
    always_comb
    begin
        stb_cond = `CSR_ZERO8;
        stb_cond[`CSR_STB_OPER] = oper_summary;
        stb_cond[`CSR_STB_ESB]  = |(event_status_r & event_status_enable_r);
        stb_cond[`CSR_STB_MAV]  = oq_cnt_r != 4'h0;
        stb_cond[`CSR_STB_QUES] = ques_summary;
        stb_cond[`CSR_STB_RQS]  = rqs_r;
        stb_cond = stb_cond & `CSR_STB_USED;
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable masks survive reset and clear status; only power-on or a write of zero clears them
    always_ff @(posedge clk_sys)
    begin
        if (por)
        begin
            event_status_enable_r    <= `CSR_ZERO8;
            service_request_enable_r <= `CSR_ZERO8;
        end
        else if (take && cmd_code == csr_pkg::CSR_CMD_ESE)
            event_status_enable_r <= cmd_arg;
        else if (take && cmd_code == csr_pkg::CSR_CMD_SRE)
            service_request_enable_r <= cmd_arg & `CSR_SRE_USED;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status: new events win over clear-on-read and clear status
    logic [7:0] ev_set;
    always_comb
    begin
        ev_set = event_in;
        if (state_r == csr_pkg::CSR_ST_DELAY && delay_r == 8'h00 && !opc_kind_r)
            ev_set[`CSR_ESR_OPC] = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (por)
            event_status_r <= 8'h01 << `CSR_ESR_PON;
        else if (is_cls || (take && cmd_code == csr_pkg::CSR_CMD_ESR_Q))
            event_status_r <= ev_set;
        else
            event_status_r <= event_status_r | ev_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // Service request: 0->1 edge of an enabled bit; bit 6 is masked out
    logic rise_hit;
    assign rise_hit = |(stb_cond & ~stb_prev_r & service_request_enable_r
                        & ~(8'h01 << `CSR_STB_RQS));

    always_ff @(posedge clk_sys)
    begin
        if (por || rst)
        begin
            stb_prev_r <= `CSR_ZERO8;
            rqs_r      <= 1'b0;
            srq        <= 1'b0;
        end
        else
        begin
            stb_prev_r <= stb_cond;
            if (rise_hit)
                rqs_r <= 1'b1;
            else if (spoll_read || is_cls)
                rqs_r <= 1'b0;
            srq <= rise_hit || (rqs_r && !spoll_read && !is_cls);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (por)
            spoll_byte <= `CSR_ZERO8;
        else
            spoll_byte <= stb_cond;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output queue, flushed by clear status right after a terminator
    assign oq_flush = is_cls && cmd_after_term;
    assign oq_do_push = oq_push && oq_cnt_r != 4'(`CSR_OQ_DEPTH);
    assign oq_do_pop  = oq_read && oq_cnt_r != 4'h0;

    always_ff @(posedge clk_sys)
    begin
        if (por || oq_flush)
        begin
            oq_wp_r  <= 3'd0;
            oq_rp_r  <= 3'd0;
            oq_cnt_r <= 4'h0;
        end
        else
        begin
            if (oq_do_push)
            begin
                oq_mem[oq_wp_r] <= oq_push_data;
                oq_wp_r <= oq_wp_r + 3'd1;
            end
            if (oq_do_pop)
                oq_rp_r <= oq_rp_r + 3'd1;
            oq_cnt_r <= oq_cnt_r + 4'(oq_do_push) - 4'(oq_do_pop);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (por || oq_flush)
        begin
            oq_data  <= `CSR_ZERO8;
            oq_valid <= 1'b0;
        end
        else
        begin
            oq_data  <= (oq_do_push && oq_cnt_r == 4'(oq_do_pop))
                        ? oq_push_data : oq_mem[oq_rp_r + 3'(oq_do_pop)];
            oq_valid <= (oq_cnt_r + 4'(oq_do_push) - 4'(oq_do_pop)) != 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Answers pushed into the output queue
    always_comb
    begin
        oq_push      = 1'b0;
        oq_push_data = `CSR_ZERO8;
        if (take)
        begin
            case (cmd_code)
                csr_pkg::CSR_CMD_ESE_Q:
                begin
                    oq_push = 1'b1;
                    oq_push_data = event_status_enable_r;
                end
                csr_pkg::CSR_CMD_ESR_Q:
                begin
                    oq_push = 1'b1;
                    oq_push_data = event_status_r;
                end
                csr_pkg::CSR_CMD_SRE_Q:
                begin
                    oq_push = 1'b1;
                    oq_push_data = service_request_enable_r;
                end
                csr_pkg::CSR_CMD_STB_Q:
                begin
                    oq_push = 1'b1;
                    oq_push_data = stb_cond;
                end
                default:
                    oq_push = 1'b0;
            endcase
        end
        else if (state_r == csr_pkg::CSR_ST_DELAY && delay_r == 8'h00 && opc_kind_r)
        begin
            oq_push = 1'b1;
            oq_push_data = `CSR_ASCII_ONE;
        end
        else if (state_r == csr_pkg::CSR_ST_TEST && test_done)
        begin
            oq_push = 1'b1;
            oq_push_data = 8'((test_result & `CSR_TST_USED) >> 8);
        end
        else if (state_r == csr_pkg::CSR_ST_IDN)
        begin
            oq_push = 1'b1;
            case (emit_r)
                3'd0: oq_push_data = `CSR_ID_MFR;
                3'd2: oq_push_data = `CSR_ID_MODEL;
                3'd4: oq_push_data = `CSR_ID_SERIAL;
                3'd6: oq_push_data = `CSR_ID_REV;
                default: oq_push_data = `CSR_ID_SEP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer
    always_ff @(posedge clk_sys)
    begin
        if (por || rst)
        begin
            state_r    <= csr_pkg::CSR_ST_IDLE;
            cmd_ready  <= 1'b0;
            delay_r    <= 8'h00;
            emit_r     <= 3'd0;
            opc_kind_r <= 1'b0;
            test_start <= 1'b0;
        end
        else
        begin
            test_start <= 1'b0;
            case (state_r)
                csr_pkg::CSR_ST_IDLE:
                begin
                    cmd_ready <= 1'b1;
                    if (take)
                    begin
                        case (cmd_code)
                            csr_pkg::CSR_CMD_OPC, csr_pkg::CSR_CMD_OPC_Q:
                            begin
                                opc_kind_r <= cmd_code == csr_pkg::CSR_CMD_OPC_Q;
                                state_r    <= csr_pkg::CSR_ST_DRAIN;
                                cmd_ready  <= 1'b0;
                            end
                            csr_pkg::CSR_CMD_WAI:
                            begin
                                opc_kind_r <= 1'b0;
                                state_r    <= csr_pkg::CSR_ST_DRAIN;
                                cmd_ready  <= 1'b0;
                                delay_r    <= 8'hff;
                            end
                            csr_pkg::CSR_CMD_TST_Q:
                            begin
                                state_r    <= csr_pkg::CSR_ST_TEST;
                                cmd_ready  <= 1'b0;
                                test_start <= 1'b1;
                            end
                            csr_pkg::CSR_CMD_IDN_Q:
                            begin
                                state_r   <= csr_pkg::CSR_ST_IDN;
                                emit_r    <= 3'd0;
                                cmd_ready <= 1'b0;
                            end
                            default:
                                state_r <= csr_pkg::CSR_ST_IDLE;
                        endcase
                    end
                end
                csr_pkg::CSR_ST_DRAIN:
                begin
                    if (!ops_pending && !queue_busy)
                    begin
                        if (delay_r == 8'hff)
                            state_r <= csr_pkg::CSR_ST_IDLE;
                        else
                            state_r <= csr_pkg::CSR_ST_DELAY;
                        delay_r <= 8'(`CSR_OPC_DELAY_CYC - 1);
                    end
                end
                csr_pkg::CSR_ST_DELAY:
                begin
                    if (delay_r == 8'h00)
                        state_r <= csr_pkg::CSR_ST_IDLE;
                    else
                        delay_r <= delay_r - 8'h01;
                end
                csr_pkg::CSR_ST_TEST:
                begin
                    if (test_done)
                        state_r <= csr_pkg::CSR_ST_IDN;
                    emit_r <= 3'd7;
                end
                csr_pkg::CSR_ST_IDN:
                begin
                    if (emit_r == 3'd6 || emit_r == 3'd7)
                        state_r <= csr_pkg::CSR_ST_IDLE;
                    emit_r <= emit_r + 3'd1;
                end
                default:
                    state_r <= csr_pkg::CSR_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instrument setting: default, save, recall, self-test restore
    always_ff @(posedge clk_sys)
    begin
        if (por || rst || (take && (cmd_code == csr_pkg::CSR_CMD_RST
            || (cmd_code == csr_pkg::CSR_CMD_RCL && cmd_arg[3:0] == 4'h0))))
        begin
            pos_pol     <= `CSR_POS_DEFAULT;
            pos_quarter <= `CSR_POS_DEFAULT;
            pos_half    <= `CSR_POS_DEFAULT;
            scan_fast   <= `CSR_RATE_FAST;
        end
        else if (take && cmd_code == csr_pkg::CSR_CMD_RCL && cmd_arg[3:0] <= `CSR_LOC_MAX)
        begin
            pos_pol     <= sav_pol[cmd_arg[3:0]];
            pos_quarter <= sav_qtr[cmd_arg[3:0]];
            pos_half    <= sav_half[cmd_arg[3:0]];
            scan_fast   <= sav_fast[cmd_arg[3:0]];
        end
        else if (state_r == csr_pkg::CSR_ST_TEST && test_done)
        begin
            pos_pol     <= tst_pol_r;
            pos_quarter <= tst_qtr_r;
            pos_half    <= tst_half_r;
            scan_fast   <= tst_fast_r;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (take && cmd_code == csr_pkg::CSR_CMD_SAV && cmd_arg[3:0] != 4'h0
            && cmd_arg[3:0] <= `CSR_LOC_MAX)
        begin
            sav_pol[cmd_arg[3:0]]  <= pos_pol;
            sav_qtr[cmd_arg[3:0]]  <= pos_quarter;
            sav_half[cmd_arg[3:0]] <= pos_half;
            sav_fast[cmd_arg[3:0]] <= scan_fast;
        end
        if (take && cmd_code == csr_pkg::CSR_CMD_TST_Q)
        begin
            tst_pol_r  <= pos_pol;
            tst_qtr_r  <= pos_quarter;
            tst_half_r <= pos_half;
            tst_fast_r <= scan_fast;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (por || rst)
            err_q_clear <= 1'b0;
        else
            err_q_clear <= is_cls;
    end
endmodule : csr_status
`default_nettype wire

// >>> common/csr_regs.svh
// Constants of the common status reporting block: field positions, codes, reset values.
// Assumes inclusion by bare name from design files; definitions only.
// Behaviour
// - Service request only on status byte 0-to-1 edge with matching enable bit set.
// - Request service bit set with the request, cleared by serial poll or clear status.
// - Unused bits of all four status registers read back as zero.
// - Clear status clears event status, status byte, error queue; not accepted while a completion action runs.
// - Clear after terminator also empties output queue and message available.
// - Event enable written 0..255; cleared at power-on or by zero; survives reset.
// - Event bits: power on, user, command, execution, device, query, request, complete.
// - Event status query returns value then clears the register.
// - Completion command finishes queued messages then sets the complete bit.
// - Completion query finishes queued work, then after a delay queues ASCII one.
// - Recall takes locations 0..9; location 0 is the default setting.
// - Save stores current setting into user locations 1 through 9.
// - Reset loads default and idles; keeps queue, both enable masks.
// - Default: all plate positions zero degrees, scan speed fast.
// - Service enable selects request bits; cleared at power-on or zero; survives reset.
// - Status byte: 7 operation, 6 request, 5 event, 4 message, 3 questionable.
// - Enable bit 6 never masks the request service bit.
// - Status byte query returns the current status byte.
// - Self-test result is a 16-bit failure sum; zero means pass. The query answers its upper byte, masked with 0x77, followed by a separator byte.
// - No commands during self-test; setting restored afterwards.
// - Wait command holds further commands until pending operations complete.
// - Identification returns manufacturer, model, serial and revision fields.
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH
`define CSR_STB_OPER      3'd7
`define CSR_STB_RQS       3'd6
`define CSR_STB_ESB       3'd5
`define CSR_STB_MAV       3'd4
`define CSR_STB_QUES      3'd3
`define CSR_STB_USED      8'hf8
`define CSR_SRE_USED      8'hb8
`define CSR_ESR_OPC       3'd0
`define CSR_ESR_PON       3'd7
`define CSR_TST_USED      16'h773b
`define CSR_ZERO8         8'h00
`define CSR_ASCII_ONE     8'h31
`define CSR_POS_DEFAULT   16'h0000
`define CSR_RATE_FAST     1'b1
`define CSR_LOC_MAX       4'h9
`define CSR_OPC_DELAY_NS  1000
`define CSR_CLK_NS        50
`define CSR_OPC_DELAY_CYC ((`CSR_OPC_DELAY_NS + `CSR_CLK_NS - 1) / `CSR_CLK_NS)
`define CSR_ID_MFR        8'h4d
`define CSR_ID_MODEL      8'h2a
`define CSR_ID_SERIAL     8'h11
`define CSR_ID_REV        8'h01
`define CSR_ID_SEP        8'h2c
`define CSR_OQ_DEPTH      8
`endif

// >>> common/csr_pkg.sv
// Types of the common status reporting block.
// Assumes no surroundings; compiled before the design.
package csr_pkg;
    typedef enum logic [3:0] {
        CSR_CMD_NONE, CSR_CMD_CLS, CSR_CMD_ESE, CSR_CMD_ESE_Q, CSR_CMD_ESR_Q,
        CSR_CMD_IDN_Q, CSR_CMD_OPC, CSR_CMD_OPC_Q, CSR_CMD_RCL, CSR_CMD_RST,
        CSR_CMD_SAV, CSR_CMD_SRE, CSR_CMD_SRE_Q, CSR_CMD_STB_Q, CSR_CMD_TST_Q,
        CSR_CMD_WAI
    } csr_cmd_t;
    typedef enum logic [2:0] {
        CSR_ST_IDLE, CSR_ST_DRAIN, CSR_ST_DELAY, CSR_ST_TEST, CSR_ST_IDN
    } csr_state_t;
endpackage : csr_pkg

// >>> tb/csr_ctl_model.sv
// Bus controller model: empties the output queue and polls on each service request.
// Assumes the bench drives stall and poll_en in the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module csr_ctl_model (
    // Clock
    input  wire logic clk_sys,
    // Bench knobs
    input  wire logic stall,
    input  wire logic poll_en,
    // Block side
    input  wire logic oq_valid,
    output logic      oq_read,
    input  wire logic srq,
    output logic      spoll_read
);
    initial oq_read = 1'b0;
    initial spoll_read = 1'b0;
    // One pop per head byte; the gap lets the next head settle
    always @(posedge clk_sys)
        oq_read <= oq_valid && !oq_read && !stall;
    // One poll per request; the next cycle is skipped so the line can drop
    always @(posedge clk_sys)
        spoll_read <= srq && !spoll_read && poll_en;
endmodule : csr_ctl_model
`default_nettype wire

// >>> tb/csr_status_asserts.sv
// Checker for the common status block, bound to every instance of it.
// Assumes one clock domain; rst and por both mask the checks.
`timescale 1ns/1ps
`default_nettype none
module csr_status_asserts (
    // Clock and resets
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              por,
    // Commands and instrument
    input wire logic              cmd_valid,
    input wire csr_pkg::csr_cmd_t cmd_code,
    input wire logic              cmd_after_term,
    input wire logic              cmd_ready,
    input wire logic              ops_pending,
    input wire logic              queue_busy,
    input wire logic              err_q_clear,
    input wire logic [15:0]       pos_pol,
    input wire logic [15:0]       pos_quarter,
    input wire logic [15:0]       pos_half,
    input wire logic              scan_fast,
    input wire logic              test_start,
    // Output queue and poll
    input wire logic [7:0]        oq_data,
    input wire logic              oq_valid,
    input wire logic              oq_read,
    input wire logic              srq,
    input wire logic              spoll_read,
    input wire logic [7:0]        spoll_byte
);
    logic cls_take;
    logic term_cls;
    assign cls_take = cmd_valid && cmd_ready && cmd_code == csr_pkg::CSR_CMD_CLS;
    assign term_cls = cls_take && cmd_after_term;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || por);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_take(csr_pkg::csr_cmd_t c); cmd_valid && cmd_ready && cmd_code == c; endsequence
    // Three cycles of backlog rule out an engine that leaves early
    sequence s_wai_busy;
        s_take(csr_pkg::CSR_CMD_WAI) ##1 (ops_pending || queue_busy)[*3];
    endsequence
    property p_unused; spoll_byte[2:0] == 3'h0; endproperty
    a_unused: assert property (p_unused) else $error("unused bits set");
    property p_srq_fall;
        $fell(srq) |-> $past(spoll_read) || $past(cls_take);
    endproperty
    a_srq_fall: assert property (p_srq_fall) else $error("request dropped");
    property p_err; s_take(csr_pkg::CSR_CMD_CLS) |=> err_q_clear; endproperty
    a_err: assert property (p_err) else $error("no error clear");
    property p_err_src; err_q_clear |-> $past(cls_take); endproperty
    a_err_src: assert property (p_err_src) else $error("stray error clear");
    property p_query; s_take(csr_pkg::CSR_CMD_STB_Q) |=> oq_valid; endproperty
    a_query: assert property (p_query) else $error("no answer");
    property p_hold;
        oq_valid && !oq_read && !term_cls && !$past(term_cls) |=> oq_valid && $stable(oq_data);
    endproperty
    a_hold: assert property (p_hold) else $error("head byte lost");
    property p_rst;
        s_take(csr_pkg::CSR_CMD_RST) |-> ##[1:2]
            (pos_pol == 16'h0000 && pos_quarter == 16'h0000 && pos_half == 16'h0000 && scan_fast);
    endproperty
    a_rst: assert property (p_rst) else $error("no default setting");
    property p_wai; s_wai_busy |-> !cmd_ready; endproperty
    a_wai: assert property (p_wai) else $error("ran while busy");
    property p_test; s_take(csr_pkg::CSR_CMD_TST_Q) |-> ##[1:2] test_start; endproperty
    a_test: assert property (p_test) else $error("no test start");
endmodule : csr_status_asserts
bind csr_status csr_status_asserts i_csr_status_asserts (.clk_sys, .rst, .por, .cmd_valid,
    .cmd_code, .cmd_after_term, .cmd_ready, .ops_pending, .queue_busy, .err_q_clear, .pos_pol,
    .pos_quarter, .pos_half, .scan_fast, .test_start, .oq_data, .oq_valid, .oq_read, .srq,
    .spoll_read, .spoll_byte);
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the common status block with a bus controller model.
// Assumes the design package and constants header are compiled first.
`include "csr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic              clk_sys = 1'b0, rst = 1'b1, por = 1'b1, cmd_valid = 1'b0;
    csr_pkg::csr_cmd_t cmd_code = csr_pkg::CSR_CMD_NONE;
    logic [7:0]        cmd_arg = 8'h00, event_in = 8'h00, oq_data, spoll_byte, r;
    logic              cmd_after_term = 1'b0, ops_pending = 1'b0, queue_busy = 1'b0;
    logic              test_done = 1'b0, stall = 1'b0, cmd_ready, err_q_clear, scan_fast;
    logic              test_start, oq_valid, oq_read, srq, spoll_read;
    logic [15:0]       test_result = 16'h0000, pos_pol, pos_quarter, pos_half, t;
    logic [7:0]        eq[$];
    integer            miscompares = 0, check_count = 0, cyc = 0, seed = 32'hc62f81cd, i;
    always #25 clk_sys = ~clk_sys;
    csr_status i_csr_status (.clk_sys, .rst, .por, .cmd_valid, .cmd_code, .cmd_arg,
        .cmd_after_term, .cmd_ready, .ops_pending, .queue_busy, .event_in,
        .oper_summary(1'b0), .ques_summary(1'b0), .err_q_clear, .pos_pol, .pos_quarter,
        .pos_half, .scan_fast, .test_start, .test_done, .test_result, .oq_data, .oq_valid,
        .oq_read, .srq, .spoll_read, .spoll_byte);
    csr_ctl_model i_csr_ctl_model (.clk_sys, .stall, .poll_en(1'b1), .oq_valid, .oq_read,
        .srq, .spoll_read);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s: saw %h wanted %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // Request held until the edge that sees ready; the leading edge keeps drives apart
    task automatic cmd(input csr_pkg::csr_cmd_t c, input logic [7:0] a);
        @(posedge clk_sys);
        cmd_code <= c;
        cmd_arg <= a;
        cmd_valid <= 1'b1;
        @(posedge clk_sys);
        while (!cmd_ready)
            @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd_after_term <= 1'b0;
    endtask : cmd
    task automatic q(input csr_pkg::csr_cmd_t c, input logic [7:0] e);
        eq.push_back(e);
        cmd(c, 8'h00);
    endtask : q
    task automatic pulse(input logic [7:0] e);
        @(posedge clk_sys);
        event_in <= e;
        @(posedge clk_sys);
        event_in <= 8'h00;
    endtask : pulse
    task automatic srq_is(input logic v);
        for (int n = 0; n < 10 && srq !== v; n++)
            @(posedge clk_sys);
        check(srq, v, "request line");
    endtask : srq_is
    task automatic drain();
        for (int n = 0; n < 300 && eq.size() != 0; n++)
            @(posedge clk_sys);
        check(16'(eq.size()), 16'h0000, "bytes missing");
    endtask : drain
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (oq_valid && oq_read)
            check(oq_data, eq.size() ? eq.pop_front() : 8'hxx, "answer byte");
        if (cyc == 20000)
        begin
            miscompares++;
            close_out();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        por <= 1'b0;
        q(csr_pkg::CSR_CMD_ESR_Q, 8'h80);
        q(csr_pkg::CSR_CMD_ESR_Q, 8'h00);
        r = 8'($random(seed));
        cmd(csr_pkg::CSR_CMD_ESE, r);
        q(csr_pkg::CSR_CMD_ESE_Q, r);
        cmd(csr_pkg::CSR_CMD_SRE, r);
        cmd(csr_pkg::CSR_CMD_RST, 8'h00);
        q(csr_pkg::CSR_CMD_SRE_Q, r & `CSR_SRE_USED);
        q(csr_pkg::CSR_CMD_ESE_Q, r);
        cmd(csr_pkg::CSR_CMD_ESE, 8'h00);
        q(csr_pkg::CSR_CMD_ESE_Q, 8'h00);
        drain();
        check(pos_pol | pos_quarter | pos_half, 16'h0000, "position");
        check(scan_fast, 1'b1, "speed");
        $display("test registers done");
        for (i = 0; i < 8; i++)
        begin
            cmd(csr_pkg::CSR_CMD_ESE, 8'h01 << i);
            cmd(csr_pkg::CSR_CMD_SRE, 8'h20);
            pulse(8'h01 << i);
            srq_is(1'b1);
            srq_is(1'b0);
            q(csr_pkg::CSR_CMD_STB_Q, 8'h20);
            q(csr_pkg::CSR_CMD_ESR_Q, 8'h01 << i);
            drain();
        end
        pulse(8'h08);
        repeat (8) @(posedge clk_sys);
        check(srq, 1'b0, "masked event");
        cmd(csr_pkg::CSR_CMD_CLS, 8'h00);
        q(csr_pkg::CSR_CMD_ESR_Q, 8'h00);
        drain();
        stall <= 1'b1;
        cmd(csr_pkg::CSR_CMD_ESE_Q, 8'h00);
        repeat (3) @(posedge clk_sys);
        check(oq_valid, 1'b1, "byte waiting");
        cmd_after_term <= 1'b1;
        cmd(csr_pkg::CSR_CMD_CLS, 8'h00);
        repeat (3) @(posedge clk_sys);
        check(oq_valid, 1'b0, "queue kept");
        stall <= 1'b0;
        $display("test status done");
        ops_pending <= 1'b1;
        cmd(csr_pkg::CSR_CMD_OPC, 8'h00);
        repeat (30) @(posedge clk_sys);
        check(cmd_ready, 1'b0, "ready while busy");
        ops_pending <= 1'b0;
        q(csr_pkg::CSR_CMD_ESR_Q, 8'h01);
        queue_busy <= 1'b1;
        cmd(csr_pkg::CSR_CMD_WAI, 8'h00);
        repeat (10) @(posedge clk_sys);
        check(cmd_ready, 1'b0, "ready in wait");
        queue_busy <= 1'b0;
        q(csr_pkg::CSR_CMD_OPC_Q, `CSR_ASCII_ONE);
        ops_pending <= 1'b1;
        repeat (25) @(posedge clk_sys);
        check(oq_valid, 1'b0, "early answer");
        ops_pending <= 1'b0;
        drain();
        $display("test completion done");
        t = 16'($random(seed));
        eq = {eq, 8'((t & `CSR_TST_USED) >> 8), `CSR_ID_SEP};
        cmd(csr_pkg::CSR_CMD_TST_Q, 8'h00);
        while (!test_start)
            @(posedge clk_sys);
        test_result <= t;
        test_done <= 1'b1;
        @(posedge clk_sys);
        test_done <= 1'b0;
        eq = {eq, `CSR_ID_MFR, `CSR_ID_SEP, `CSR_ID_MODEL, `CSR_ID_SEP, `CSR_ID_SERIAL,
              `CSR_ID_SEP, `CSR_ID_REV};
        cmd(csr_pkg::CSR_CMD_IDN_Q, 8'h00);
        cmd(csr_pkg::CSR_CMD_SAV, 8'h09);
        cmd(csr_pkg::CSR_CMD_RCL, 8'h0a);
        cmd(csr_pkg::CSR_CMD_RCL, 8'h00);
        drain();
        check(pos_pol | pos_quarter | pos_half, 16'h0000, "recalled position");
        $display("test identity done");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
